// ==== rtl/compare_skip_params.svh ====
// constants for the compare-and-skip decode and execute block
`ifndef COMPARE_SKIP_PARAMS_SVH
`define COMPARE_SKIP_PARAMS_SVH
`define OPC_HI 15
`define OPC_LO 9
`define OPC_GREATER 7'h32
`define OPC_LESS 7'h30
`define BANK_BIT 8
`define FILE_HI 7
`define FILE_LO 0
`define INDEXED_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h80
`define ACCESS_HIGH_BANK 4'hF
`define BANK_ZERO 4'h0
`define NOP_WORD 16'hF000
`define ZERO_BYTE 8'h00
`define ZERO_ADDR 12'h000
`define ZERO_CYCLES 2'h0
`define ONE_CYCLE 2'h1
`define TWO_CYCLES 2'h2
`define PHASE_RESET 4'h1
`endif

// ==== rtl/compare_skip_pkg.sv ====
// types shared by the compare-and-skip block
package compare_skip_pkg;
	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} phase_t;
	typedef enum logic [2:0] {
		ST_EXEC = 3'b001,
		ST_FLUSH = 3'b010,
		ST_FLUSH2 = 3'b100
	} seq_t;
endpackage

// ==== rtl/skip_opcode_decoder.sv ====
// combinational decode of the two compare-and-skip words
`include "compare_skip_params.svh"
module skip_opcode_decoder (
	input wire logic [15:0] word_in,
	output logic is_greater_out,
	output logic is_less_out,
	output logic bank_bit_out,
	output logic [7:0] file_addr_out
);
	always_comb begin
		is_greater_out = (word_in[`OPC_HI:`OPC_LO] == `OPC_GREATER);
		is_less_out = (word_in[`OPC_HI:`OPC_LO] == `OPC_LESS);
		bank_bit_out = word_in[`BANK_BIT];
		file_addr_out = word_in[`FILE_HI:`FILE_LO];
	end
endmodule

// ==== rtl/skip_address_former.sv ====
// forms the 12-bit data address from file address, bank bit and bank select
`include "compare_skip_params.svh"
module skip_address_former (
	input wire logic [7:0] file_addr_in,
	input wire logic bank_bit_in,
	input wire logic [3:0] bank_select_reg_in,
	input wire logic extended_mode_in,
	input wire logic [11:0] index_base_in,
	output logic [11:0] data_addr_out,
	output logic indexed_out
);
	logic [11:0] offset_ext;
	always_comb begin
		offset_ext = {4'h0, file_addr_in};
		indexed_out = 1'b0;
		if (bank_bit_in) begin
			data_addr_out = {bank_select_reg_in, file_addr_in};
		end else if (extended_mode_in && file_addr_in <= `INDEXED_LIMIT) begin
			indexed_out = 1'b1;
			data_addr_out = 12'(index_base_in + offset_ext);
		end else if (file_addr_in < `ACCESS_SPLIT) begin
			data_addr_out = {`BANK_ZERO, file_addr_in};
		end else begin
			data_addr_out = {`ACCESS_HIGH_BANK, file_addr_in};
		end
	end
endmodule

// ==== rtl/compare_skip_instructions.sv ====
// decode and execute of the greater and less compare-and-skip instructions
`include "compare_skip_params.svh"
module compare_skip_instructions (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [15:0] instr_word_in,
	input wire logic next_two_word_in,
	input wire logic [7:0] working_register_in,
	input wire logic [3:0] bank_select_reg_in,
	input wire logic extended_mode_in,
	input wire logic [11:0] index_base_in,
	input wire logic [7:0] data_rd_in,
	output logic [3:0] phase_out,
	output logic busy_out,
	output logic data_rd_en_out,
	output logic [11:0] data_addr_out,
	output logic indexed_out,
	output logic skip_out,
	output logic discard_out,
	output logic [15:0] exec_word_out,
	output logic [1:0] flush_left_out,
	output logic instr_done_out
);
	compare_skip_pkg::phase_t phase_q;
	compare_skip_pkg::seq_t seq_q;
	logic is_greater;
	logic is_less;
	logic bank_bit;
	logic [7:0] file_addr;
	logic [11:0] addr_formed;
	logic indexed_formed;
	logic greater_q;
	logic less_q;
	logic two_word_q;
	logic cmp_skip;
	// next values of the sequencer and of the registered outputs
	compare_skip_pkg::seq_t seq_d;
	logic [1:0] flush_left_d;
	logic take_word;
	logic start_compare;
	logic skip_d;
	logic done_d;
	logic discard_d;
	logic busy_d;

	skip_opcode_decoder u_dec (
		.word_in(instr_word_in),
		.is_greater_out(is_greater),
		.is_less_out(is_less),
		.bank_bit_out(bank_bit),
		.file_addr_out(file_addr)
	);

	skip_address_former u_addr (
		.file_addr_in(file_addr),
		.bank_bit_in(bank_bit),
		.bank_select_reg_in(bank_select_reg_in),
		.extended_mode_in(extended_mode_in),
		.index_base_in(index_base_in),
		.data_addr_out(addr_formed),
		.indexed_out(indexed_formed)
	);

	// unsigned compare of the byte just read against the working register
	always_comb begin
		cmp_skip = 1'b0;
		if (greater_q && (data_rd_in > working_register_in)) begin
			cmp_skip = 1'b1;
		end
		if (less_q && (data_rd_in < working_register_in)) begin
			cmp_skip = 1'b1;
		end
	end

	// four-phase instruction clock
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			phase_q <= compare_skip_pkg::PH_Q1;
		end else begin
			case (phase_q)
				compare_skip_pkg::PH_Q1: phase_q <= compare_skip_pkg::PH_Q2;
				compare_skip_pkg::PH_Q2: phase_q <= compare_skip_pkg::PH_Q3;
				compare_skip_pkg::PH_Q3: phase_q <= compare_skip_pkg::PH_Q4;
				compare_skip_pkg::PH_Q4: phase_q <= compare_skip_pkg::PH_Q1;
				default: phase_q <= compare_skip_pkg::PH_Q1;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			phase_out <= `PHASE_RESET;
		end else begin
			case (phase_q)
				compare_skip_pkg::PH_Q1: phase_out <= compare_skip_pkg::PH_Q2;
				compare_skip_pkg::PH_Q2: phase_out <= compare_skip_pkg::PH_Q3;
				compare_skip_pkg::PH_Q3: phase_out <= compare_skip_pkg::PH_Q4;
				default: phase_out <= compare_skip_pkg::PH_Q1;
			endcase
		end
	end

	// sequencer next state: a skip arms the flush count in Q3, flushing starts after Q4
	always_comb begin
		seq_d = seq_q;
		flush_left_d = flush_left_out;
		case (seq_q)
			compare_skip_pkg::ST_EXEC: begin
				if (phase_q == compare_skip_pkg::PH_Q3 && cmp_skip) begin
					flush_left_d = two_word_q ? `TWO_CYCLES : `ONE_CYCLE;
				end
				if (phase_q == compare_skip_pkg::PH_Q4 && flush_left_out != `ZERO_CYCLES) begin
					seq_d = compare_skip_pkg::ST_FLUSH;
				end
			end
			compare_skip_pkg::ST_FLUSH: begin
				if (phase_q == compare_skip_pkg::PH_Q4) begin
					if (flush_left_out == `TWO_CYCLES) begin
						seq_d = compare_skip_pkg::ST_FLUSH2;
					end else begin
						seq_d = compare_skip_pkg::ST_EXEC;
					end
					flush_left_d = flush_left_out - `ONE_CYCLE;
				end
			end
			compare_skip_pkg::ST_FLUSH2: begin
				if (phase_q == compare_skip_pkg::PH_Q4) begin
					seq_d = compare_skip_pkg::ST_EXEC;
					flush_left_d = `ZERO_CYCLES;
				end
			end
			default: begin
				seq_d = compare_skip_pkg::ST_EXEC;
				flush_left_d = `ZERO_CYCLES;
			end
		endcase
	end

	// compare side: strobes of the execute cycle, one clock ahead of the outputs
	always_comb begin
		take_word = (phase_q == compare_skip_pkg::PH_Q1) &&
			(seq_q == compare_skip_pkg::ST_EXEC);
		start_compare = take_word && (is_greater || is_less);
		skip_d = (phase_q == compare_skip_pkg::PH_Q3) &&
			(seq_q == compare_skip_pkg::ST_EXEC) && cmp_skip;
		done_d = (phase_q == compare_skip_pkg::PH_Q3) &&
			(seq_q == compare_skip_pkg::ST_EXEC) && (greater_q || less_q);
	end

	// flush side: taken from the next state so the level ends with the last flush phase
	always_comb begin
		discard_d = (seq_d != compare_skip_pkg::ST_EXEC);
		busy_d = discard_d || start_compare ||
			((greater_q || less_q) && (phase_q != compare_skip_pkg::PH_Q4));
	end

	// execute / flush sequencer state
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			seq_q <= compare_skip_pkg::ST_EXEC;
		end else begin
			seq_q <= seq_d;
		end
	end

	// no-operation cycles still to run after a skip
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			flush_left_out <= `ZERO_CYCLES;
		end else begin
			flush_left_out <= flush_left_d;
		end
	end

	// skip pulse in Q4 of the compare cycle
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			skip_out <= 1'b0;
		end else begin
			skip_out <= skip_d;
		end
	end

	// discard level for every phase of a flush cycle
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			discard_out <= 1'b0;
		end else begin
			discard_out <= discard_d;
		end
	end

	// discarded word replaced by a no-operation
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			exec_word_out <= `NOP_WORD;
		end else if (discard_d) begin
			exec_word_out <= `NOP_WORD;
		end else begin
			exec_word_out <= instr_word_in;
		end
	end

	// busy through Q2 to Q4 of a compare and through every flush cycle
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			busy_out <= 1'b0;
		end else begin
			busy_out <= busy_d;
		end
	end

	// done pulse in Q4 of a compare cycle
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			instr_done_out <= 1'b0;
		end else begin
			instr_done_out <= done_d;
		end
	end

	// data read strobe during Q2 only; nothing is ever written back
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			data_rd_en_out <= 1'b0;
		end else begin
			data_rd_en_out <= start_compare;
		end
	end

	// Q1 latches the decode; held for the rest of the instruction cycle
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			greater_q <= 1'b0;
		end else if (take_word) begin
			greater_q <= is_greater;
		end else if (phase_q == compare_skip_pkg::PH_Q4) begin
			greater_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			less_q <= 1'b0;
		end else if (take_word) begin
			less_q <= is_less;
		end else if (phase_q == compare_skip_pkg::PH_Q4) begin
			less_q <= 1'b0;
		end
	end

	// length of the word after the compare, known at decode
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			two_word_q <= 1'b0;
		end else if (take_word) begin
			two_word_q <= next_two_word_in;
		end
	end

	// data address stands from Q2 until the next word is taken
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			data_addr_out <= `ZERO_ADDR;
		end else if (take_word) begin
			data_addr_out <= addr_formed;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			indexed_out <= 1'b0;
		end else if (take_word) begin
			indexed_out <= indexed_formed;
		end
	end
endmodule

// ==== tb/compare_skip_properties.sv ====
// port assertions for the compare-and-skip block
module compare_skip_checker (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [15:0] instr_word_in,
	input wire logic [3:0] bank_select_reg_in,
	input wire logic [3:0] phase_out,
	input wire logic data_rd_en_out,
	input wire logic [11:0] data_addr_out,
	input wire logic skip_out,
	input wire logic discard_out,
	input wire logic [15:0] exec_word_out,
	input wire logic [1:0] flush_left_out,
	input wire logic instr_done_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	property p_rd_phase;
		data_rd_en_out |-> phase_out == 4'h2 ##1 !data_rd_en_out;
	endproperty
	a_rd_phase: assert property (p_rd_phase) else $error("read strobe out of phase");
	property p_done_after_rd;
		data_rd_en_out |-> ##2 instr_done_out && phase_out == 4'h8;
	endproperty
	a_done_after_rd: assert property (p_done_after_rd) else $error("done not two after read");
	property p_decode;
		data_rd_en_out |-> $past(instr_word_in[15:9]) inside {7'h32, 7'h30};
	endproperty
	a_decode: assert property (p_decode) else $error("read for a foreign word");
	property p_bank_sel;
		data_rd_en_out && $past(instr_word_in[8])
			|-> data_addr_out == {$past(bank_select_reg_in), $past(instr_word_in[7:0])};
	endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("banked address wrong");
	property p_skip_done;
		skip_out |-> instr_done_out && flush_left_out inside {2'h1, 2'h2};
	endproperty
	a_skip_done: assert property (p_skip_done) else $error("skip without done or count");
	property p_flush_one;
		skip_out && flush_left_out == 2'h1 |=> discard_out [*4] ##1 !discard_out;
	endproperty
	a_flush_one: assert property (p_flush_one) else $error("single flush length");
	property p_flush_two;
		skip_out && flush_left_out == 2'h2 |=> discard_out [*8] ##1 !discard_out;
	endproperty
	a_flush_two: assert property (p_flush_two) else $error("double flush length");
	property p_nop_word;
		discard_out |-> exec_word_out == 16'hF000 && !data_rd_en_out && !skip_out;
	endproperty
	a_nop_word: assert property (p_nop_word) else $error("flush cycle not idle");
endmodule
bind compare_skip_instructions compare_skip_checker u_chk (.clk_sys_in, .reset_in,
	.instr_word_in, .bank_select_reg_in, .phase_out, .data_rd_en_out, .data_addr_out,
	.skip_out, .discard_out, .exec_word_out, .flush_left_out, .instr_done_out);

// ==== tb/data_memory_model.sv ====
// data memory far side: answers a read strobe with its byte one clock later
module data_memory_model (
	input wire logic clk_sys_in,
	input wire logic rd_en_in,
	input wire logic [7:0] byte_in,
	output logic [7:0] data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial data_out = 8'h00;
	// outside the answer cycle the bus shows the inverse of its last value
	always @(posedge clk_sys_in) begin
		data_out <= rd_en_in ? byte_in : ~data_out;
	end
endmodule

// ==== tb/compare_skip_instructions_test.sv ====
// self-checking bench for the compare-and-skip block
module compare_skip_instructions_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'b0, reset_in = 1'b1, next_two_word_in = 1'b0, extended_mode_in = 1'b0;
	logic [15:0] instr_word_in = 16'h0000, exec_word_out;
	logic [7:0] working_register_in = 8'h00, mem_byte = 8'h00, data_rd_in;
	logic [3:0] bank_select_reg_in = 4'h0, phase_out;
	logic [11:0] index_base_in = 12'h000, data_addr_out;
	logic busy_out, data_rd_en_out, indexed_out, skip_out, discard_out, instr_done_out;
	logic [1:0] flush_left_out;
	int errors = 0, total_checks = 0, cycles = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	compare_skip_instructions DUT (.clk_sys_in, .reset_in, .instr_word_in, .next_two_word_in,
		.working_register_in, .bank_select_reg_in, .extended_mode_in, .index_base_in,
		.data_rd_in, .phase_out, .busy_out, .data_rd_en_out, .data_addr_out, .indexed_out,
		.skip_out, .discard_out, .exec_word_out, .flush_left_out, .instr_done_out);
	data_memory_model mem (.clk_sys_in, .rd_en_in(data_rd_en_out), .byte_in(mem_byte),
		.data_out(data_rd_in));
	task print_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk_bit(string name, logic e, logic g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %b seen %b", name, e, g);
		end
	endtask
	task chk_val(string name, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic run_instr(int i, logic [6:0] opc);
		logic [7:0] f, w, d;
		logic a, cmp, skp, ix;
		logic [11:0] ea;
		int n;
		f = (i % 5 == 0) ? 8'h5F : (i % 5 == 1) ? 8'h60 : (i % 5 == 2) ? 8'hFF : 8'($urandom);
		a = 1'($urandom);
		w = 8'($urandom);
		d = (i % 4 == 0) ? w : 8'($urandom);
		n = 0;
		while (!(phase_out === 4'h1 && discard_out === 1'b0) && n < 20) begin
			@(negedge clk_sys_in);
			n++;
		end
		chk_bit("aligned", 1'b1, n < 20);
		instr_word_in = {opc, a, f};
		working_register_in = w;
		mem_byte = d;
		next_two_word_in = 1'($urandom);
		extended_mode_in = 1'($urandom);
		bank_select_reg_in = 4'($urandom);
		index_base_in = 12'($urandom);
		cmp = (opc == 7'h32) || (opc == 7'h30);
		skp = cmp && ((opc == 7'h32) ? (d > w) : (d < w));
		ix = !a && extended_mode_in && (f <= 8'h5F);
		ea = a ? {bank_select_reg_in, f} : ix ? index_base_in + 12'(f) : {(f[7] ? 4'hF : 4'h0), f};
		@(negedge clk_sys_in);
		instr_word_in = ~instr_word_in;
		chk_bit("read strobe", cmp, data_rd_en_out);
		chk_bit("busy", cmp, busy_out);
		chk_val("phase", 16'h0002, 16'(phase_out));
		chk_val("exec word", {opc, a, f}, exec_word_out);
		if (cmp) begin
			chk_val("address", 16'(ea), 16'(data_addr_out));
			chk_bit("indexed", ix, indexed_out);
		end
		repeat (2) @(negedge clk_sys_in);
		chk_bit("skip", skp, skip_out);
		chk_bit("done", cmp, instr_done_out);
		n = skp ? (next_two_word_in ? 2 : 1) : 0;
		chk_val("flush left", 16'(n), 16'(flush_left_out));
		@(negedge clk_sys_in);
		n = 0;
		while (discard_out === 1'b1 && n < 12) begin
			chk_val("nop word", 16'hF000, exec_word_out);
			chk_bit("busy in flush", 1'b1, busy_out);
			n++;
			@(negedge clk_sys_in);
		end
		chk_bit("busy idle", 1'b0, busy_out);
		chk_val("nop cycles", 16'(skp ? (next_two_word_in ? 8 : 4) : 0), 16'(n));
	endtask
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(80520));
		repeat (3) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		reset_in = 1'b0;
		for (int i = 0; i < 60; i++) begin
			run_instr(i, (i % 3 == 2) ? 7'($urandom) : (i % 3 == 1) ? 7'h32 : 7'h30);
		end
		print_verdict();
	end
endmodule
